// *** design/simul_adc_readout_ctrl.sv ***
// Conversion control, power-down decode and result readout of an 8-channel sampling ADC
//
// Behaviour
// - Parallel: byte-order pin carries bit 16, then 0
// - Byte mode order high/mid/low, reversed when low
// - Parallel: lines 13..9 carry bits 15..11
// - Parallel: line 8 bit 10, then zero
// - Byte mode: line 8 always high impedance
// - Serial lane B carries channels 5..8
// - Parallel: line 7 bit 9, then zero
// - Serial lane A carries channels 1..4
// - Parallel: lines 6..0 bits 8..2, then zeros
// - Byte mode: three bytes, MSB on line 7
// - Power-down low: standby if range high, else shutdown
// - Standby keeps reference; shutdown turns everything off
// - One common trigger edge samples all channels
// - Busy rises at conversion, bounded by maximum time
// - Busy falls only when results are stored
// - Parallel: channel 1 upper bits first, then in order
// - All eight channels converted and read out
// - First-channel flag high during channel 1 only
// - Chip select high ends frame, outputs released
// - Triggers ignored while busy
// - Read during busy returns previous sample
`timescale 1ns/1ps
`include "adc_readout_regs.svh"
module simul_adc_readout_ctrl
  import adc_readout_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_sample_trigger_group1,
  input wire logic i_sample_trigger_group2,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_power_down_n,
  input wire logic i_range,
  input wire logic i_interface_select,
  input wire logic i_serial_or_byte_select,
  input wire logic i_byte_order_select,
  input wire logic [143:0] i_adc_data,
  output logic o_busy,
  output logic [15:0] o_parallel_data_lines,
  output logic [15:0] o_parallel_data_oe_n,
  output logic o_first_channel_flag,
  output logic o_first_channel_flag_oe_n,
  output logic o_front_end_power_on,
  output logic o_reference_power_on
);
  result_bank_if bank_bus ();

  result_bank u_result_bank (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .bus(bank_bus.bank)
  );

  // Pin synchronisers; sync1 feeds only sync2
  logic [`SYNC_W-1:0] sync1_reg;
  logic [`SYNC_W-1:0] sync2_reg;
  logic [`SYNC_W-1:0] prev_reg;
  wire [`SYNC_W-1:0] pin_raw = {i_byte_order_select, i_serial_or_byte_select, i_interface_select, i_range,
    i_power_down_n, i_rd_n, i_cs_n, i_sample_trigger_group2, i_sample_trigger_group1};

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_reg <= `SYNC_RESET;
      sync2_reg <= `SYNC_RESET;
      prev_reg <= `SYNC_RESET;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  wire cs_n_s = sync2_reg[`SYNC_CS];
  wire rd_n_s = sync2_reg[`SYNC_RD];
  wire pd_n_s = sync2_reg[`SYNC_PD];
  wire range_s = sync2_reg[`SYNC_RANGE];
  wire high_byte_first_enable_s = sync2_reg[`SYNC_HIGH_BYTE_FIRST_ENABLE];
  wire trig1_rise = sync2_reg[`SYNC_TRIG1] & ~prev_reg[`SYNC_TRIG1];
  wire trig2_rise = sync2_reg[`SYNC_TRIG2] & ~prev_reg[`SYNC_TRIG2];
  wire cs_rise = cs_n_s & ~prev_reg[`SYNC_CS];

  // Interface mode decode
  iface_mode_t mode;
  assign mode = !sync2_reg[`SYNC_ISEL] ? MODE_PARALLEL :
                sync2_reg[`SYNC_SBSEL] ? MODE_BYTE : MODE_SERIAL;

  // Power-down decode: standby keeps the reference alive, shutdown drops all
  logic front_end_reg;
  logic reference_reg;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      front_end_reg <= 1'b1;
      reference_reg <= 1'b1;
    end else begin
      front_end_reg <= pd_n_s;
      reference_reg <= pd_n_s | range_s;
    end
  end

  // Conversion control
  conv_state_t state_reg;
  conv_state_t state_next;
  logic [`CONV_CNT_W-1:0] cnt_reg;
  logic arm1_reg;
  logic arm2_reg;
  logic busy_reg;

  // Triggers only count while idle and powered; a half-armed pair waits for its partner
  wire trig_open = (state_reg == CONV_IDLE) & pd_n_s;
  wire conv_start = trig_open & (arm1_reg | trig1_rise) & (arm2_reg | trig2_rise);
  wire conv_done = (state_reg == CONV_RUN) & (cnt_reg == `CONV_CNT_W'(`CONV_CYCLES - 1));

  always_comb begin
    case (state_reg)
      CONV_IDLE: state_next = conv_start ? CONV_RUN : CONV_IDLE;
      CONV_RUN: state_next = conv_done ? CONV_IDLE : CONV_RUN;
      default: state_next = CONV_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= CONV_IDLE;
      cnt_reg <= 12'h000;
      arm1_reg <= 1'b0;
      arm2_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (state_reg == CONV_RUN) ? cnt_reg + 12'h001 : 12'h000;
      arm1_reg <= !conv_start & trig_open & (arm1_reg | trig1_rise);
      arm2_reg <= !conv_start & trig_open & (arm2_reg | trig2_rise);
      busy_reg <= conv_start | ((state_reg == CONV_RUN) & !conv_done);
    end
  end

  // All eight results land in the bank on the edge busy falls
  assign bank_bus.load = conv_done;
  assign bank_bus.load_data = i_adc_data;

  // Read sequencing: chan_reg/part_reg name the slice the next read edge presents
  logic [2:0] chan_reg;
  logic [4:0] part_reg;
  wire read_edge = ~cs_n_s & ~rd_n_s & (prev_reg[`SYNC_RD] | prev_reg[`SYNC_CS]);
  wire [4:0] last_part = (mode == MODE_PARALLEL) ? `PAR_LAST_PART :
                         (mode == MODE_BYTE) ? `BYTE_LAST_PART : `SER_LAST_PART;
  wire [2:0] last_chan = (mode == MODE_SERIAL) ? `SER_LAST_CHAN : `LAST_CHAN;
  wire part_wrap = (part_reg == last_part);

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      chan_reg <= 3'h0;
      part_reg <= 5'h00;
    end else if (cs_rise | conv_done) begin
      // A fresh sample always reads out from channel 1, even if chip select stayed low
      chan_reg <= 3'h0;
      part_reg <= 5'h00;
    end else if (read_edge) begin
      part_reg <= part_wrap ? 5'h00 : part_reg + 5'h01;
      chan_reg <= !part_wrap ? chan_reg : (chan_reg == last_chan) ? 3'h0 : chan_reg + 3'h1;
    end
  end

  assign bank_bus.sel_a = chan_reg;
  assign bank_bus.sel_b = chan_reg | `LANE_B_CHAN;
  wire [17:0] res = bank_bus.res_a;

  // Parallel: upper 16 bits, then the last two on lines 15 and 14 with the rest low
  wire [15:0] par_word = (part_reg == 5'h00) ? res[17:2] : {res[1:0], 14'h0000};

  // Byte order: high byte first when the order pin is high, else low byte first
  wire [1:0] byte_idx = high_byte_first_enable_s ? part_reg[1:0] : 2'h2 - part_reg[1:0];
  wire [7:0] byte_val = (byte_idx == 2'h0) ? res[17:10] :
                        (byte_idx == 2'h1) ? res[9:2] : {res[1:0], 6'h00};

  wire [4:0] ser_bit = `RESULT_MSB - part_reg;
  wire lane_a = bank_bus.res_a[ser_bit];
  wire lane_b = bank_bus.res_b[ser_bit];
  wire [15:0] ser_word = {7'h00, lane_b, lane_a, 7'h00};

  wire [15:0] word_next = (mode == MODE_PARALLEL) ? par_word :
                          (mode == MODE_BYTE) ? {8'h00, byte_val} : ser_word;
  // Byte mode leaves line 8 undriven; select lines stay inputs outside parallel mode
  wire [15:0] oe_next = (mode == MODE_PARALLEL) ? `OE_PAR_N :
                        (mode == MODE_BYTE) ? `OE_BYTE_N : `OE_SER_N;

  logic [15:0] data_reg;
  logic [15:0] oe_reg;
  logic flag_reg;
  logic flag_oe_reg;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      data_reg <= 16'h0000;
      oe_reg <= `OE_OFF_N;
      flag_reg <= 1'b0;
      flag_oe_reg <= 1'b1;
    end else if (cs_rise) begin
      oe_reg <= `OE_OFF_N;
      flag_oe_reg <= 1'b1;
      flag_reg <= 1'b0;
    end else if (read_edge) begin
      data_reg <= word_next;
      oe_reg <= oe_next;
      flag_reg <= (chan_reg == 3'h0);
      flag_oe_reg <= 1'b0;
    end
  end

  assign o_busy = busy_reg;
  assign o_parallel_data_lines = data_reg;
  assign o_parallel_data_oe_n = oe_reg;
  assign o_first_channel_flag = flag_reg;
  assign o_first_channel_flag_oe_n = flag_oe_reg;
  assign o_front_end_power_on = front_end_reg;
  assign o_reference_power_on = reference_reg;

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  logic [`CONV_CNT_W-1:0] busy_len_reg;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_len_reg <= 12'h000;
    end else begin
      busy_len_reg <= busy_reg ? busy_len_reg + 12'h001 : 12'h000;
    end
  end

  sequence start_seen;
    conv_start;
  endsequence
  sequence busy_window;
    busy_reg [*8];
  endsequence

  busy_rise_a: assert property (start_seen |=> busy_window) else $error("busy not held after start");
  busy_bound_a: assert property (busy_len_reg <= `CONV_CNT_W'(`CONV_CYCLES)) else $error("busy too long");
  busy_fall_load_a: assert property ($fell(busy_reg) |-> $past(bank_bus.load)) else $error("busy fell unloaded");
  trig_ignored_a: assert property (busy_reg |-> !conv_start) else $error("trigger accepted while busy");
  first_flag_a: assert property (read_edge && chan_reg == 3'h0 |=> flag_reg && !flag_oe_reg)
    else $error("first flag missing");
  par_upper_a: assert property (read_edge && mode == MODE_PARALLEL && part_reg == 5'h00 |=>
    data_reg == $past(res[17:2])) else $error("parallel upper word wrong");
  par_lower_a: assert property (read_edge && mode == MODE_PARALLEL && part_reg == 5'h01 |=>
    data_reg[13:0] == 14'h0000 && data_reg[14] == $past(res[0])) else $error("parallel low word wrong");
  byte_high_a: assert property (read_edge && mode == MODE_BYTE && high_byte_first_enable_s && part_reg == 5'h00 |=>
    data_reg[7:0] == $past(res[17:10])) else $error("byte order wrong");
  byte_line8_a: assert property (read_edge && mode == MODE_BYTE |=> oe_reg[8]) else $error("line 8 driven");
  serial_lanes_a: assert property (read_edge && mode == MODE_SERIAL |=> !oe_reg[8] && !oe_reg[7])
    else $error("serial lanes not driven");
  frame_end_a: assert property (cs_rise |=> oe_reg == `OE_OFF_N && flag_oe_reg) else $error("frame not released");
  shutdown_a: assert property (!pd_n_s && !range_s |=> !reference_reg && !front_end_reg)
    else $error("shutdown not applied");

  // Reads since the frame opened, counted apart from the read pointer
  logic [7:0] reads_reg;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      reads_reg <= 8'h00;
    end else if (cs_rise | conv_done) begin
      reads_reg <= 8'h00;
    end else if (read_edge && reads_reg != 8'hFF) begin
      reads_reg <= reads_reg + 8'h01;
    end
  end

  sequence par_hi_read;
    read_edge && mode == MODE_PARALLEL && part_reg == 5'h00;
  endsequence
  sequence par_lo_read;
    read_edge && mode == MODE_PARALLEL && part_reg == 5'h01;
  endsequence
  sequence byte_first_read;
    read_edge && mode == MODE_BYTE && part_reg == 5'h00;
  endsequence
  sequence byte_mid_read;
    read_edge && mode == MODE_BYTE && part_reg == 5'h01;
  endsequence
  sequence byte_last_read;
    read_edge && mode == MODE_BYTE && part_reg == 5'h02;
  endsequence
  sequence ser_msb_read;
    read_edge && mode == MODE_SERIAL && part_reg == 5'h00;
  endsequence
  // Channel 1 spans 2, 3 or 18 reads depending on the mode
  sequence flag_early_read;
    read_edge && ((mode == MODE_PARALLEL && reads_reg < 8'h02) || (mode == MODE_BYTE && reads_reg < 8'h03) ||
      (mode == MODE_SERIAL && reads_reg < 8'h12));
  endsequence
  sequence flag_late_read;
    read_edge && ((mode == MODE_PARALLEL && reads_reg >= 8'h02 && reads_reg < 8'h10) ||
      (mode == MODE_BYTE && reads_reg >= 8'h03 && reads_reg < 8'h18) ||
      (mode == MODE_SERIAL && reads_reg >= 8'h12 && reads_reg < 8'h48));
  endsequence

  par_high_byte_first_enable_pin_a: assert property (par_hi_read |=> data_reg[14] == $past(res[16]))
    else $error("byte-order line lost bit 16");
  par_mid_lines_a: assert property (par_hi_read |=> data_reg[13:9] == $past(res[15:11]))
    else $error("lines 13 to 9 wrong");
  par_line8_a: assert property (par_hi_read |=> data_reg[8] == $past(res[10]))
    else $error("line 8 lost bit 10");
  par_line8_zero_a: assert property (par_lo_read |=> !data_reg[8])
    else $error("line 8 not zero on second read");
  par_line7_a: assert property (par_hi_read |=> data_reg[7] == $past(res[9]))
    else $error("line 7 lost bit 9");
  par_line7_zero_a: assert property (par_lo_read |=> !data_reg[7])
    else $error("line 7 not zero on second read");
  par_low_lines_a: assert property (par_hi_read |=> data_reg[6:0] == $past(res[8:2]))
    else $error("lines 6 to 0 wrong");
  par_oe_a: assert property (par_hi_read |=> oe_reg == `OE_PAR_N && !flag_oe_reg)
    else $error("parallel bus not driven");
  byte_first_a: assert property (byte_first_read |=>
    data_reg[7:0] == ($past(high_byte_first_enable_s) ? $past(res[17:10]) : {$past(res[1:0]), 6'h00})) else $error("first byte wrong");
  byte_mid_a: assert property (byte_mid_read |=> data_reg[7:0] == $past(res[9:2]))
    else $error("middle byte wrong");
  byte_last_a: assert property (byte_last_read |=>
    data_reg[7:0] == ($past(high_byte_first_enable_s) ? {$past(res[1:0]), 6'h00} : $past(res[17:10]))) else $error("last byte wrong");
  byte_oe_a: assert property (byte_first_read |=> oe_reg == `OE_BYTE_N)
    else $error("byte lanes not driven");
  ser_lane_a_a: assert property (ser_msb_read |=> data_reg[7] == $past(res[17]))
    else $error("lane A msb wrong");
  ser_lane_b_a: assert property (ser_msb_read |=> data_reg[8] == $past(bank_bus.res_b[17]))
    else $error("lane B msb wrong");
  flag_ch1_a: assert property (flag_early_read |=> flag_reg)
    else $error("flag low during channel 1");
  flag_others_a: assert property (flag_late_read |=> !flag_reg)
    else $error("flag high after channel 1");
  chan_step_a: assert property (read_edge && mode == MODE_PARALLEL && part_reg == 5'h01 && chan_reg != 3'h7
    && !conv_done |=> chan_reg == $past(chan_reg) + 3'h1) else $error("channel order broken");
  ptr_restart_a: assert property (conv_done |=> chan_reg == 3'h0 && part_reg == 5'h00)
    else $error("new sample not read from channel 1");
  busy_end_a: assert property (conv_done |=> !busy_reg)
    else $error("busy held after results stored");
  standby_a: assert property (!pd_n_s && range_s |=> reference_reg && !front_end_reg)
    else $error("standby not applied");
  flag_release_a: assert property (cs_rise |=> !flag_reg)
    else $error("flag not cleared at frame end");
endmodule

// *** design/adc_readout_regs.svh ***
// Timing counts, field positions and reset values of the sampling ADC readout control
`ifndef ADC_READOUT_REGS_SVH
`define ADC_READOUT_REGS_SVH

`define REF_CLK_MHZ 250
`define CONV_TIME_MAX_NS 2000
`define CONV_CYCLES ((`CONV_TIME_MAX_NS * `REF_CLK_MHZ) / 1000)
`define CONV_CNT_W 12
`define STANDBY_EXIT_US 100
`define SHUTDOWN_EXIT_MS 13

`define RESULT_W 18
`define CHAN_COUNT 8
`define RESULT_MSB 5'h11
`define LAST_CHAN 3'h7
`define SER_LAST_CHAN 3'h3
`define LANE_B_CHAN 3'h4
`define PAR_LAST_PART 5'h01
`define BYTE_LAST_PART 5'h02
`define SER_LAST_PART 5'h11

`define SYNC_W 9
`define SYNC_TRIG1 0
`define SYNC_TRIG2 1
`define SYNC_CS 2
`define SYNC_RD 3
`define SYNC_PD 4
`define SYNC_RANGE 5
`define SYNC_ISEL 6
`define SYNC_SBSEL 7
`define SYNC_HIGH_BYTE_FIRST_ENABLE 8
`define SYNC_RESET 9'h01C

`define OE_PAR_N 16'h0000
`define OE_BYTE_N 16'hFF00
`define OE_SER_N 16'hFE7F
`define OE_OFF_N 16'hFFFF

`endif

// *** design/adc_readout_pkg.sv ***
// Types shared by the sampling ADC readout control
package adc_readout_pkg;
  typedef enum logic [1:0] {MODE_PARALLEL, MODE_BYTE, MODE_SERIAL} iface_mode_t;
  typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_t;
endpackage

// *** design/result_bank_if.sv ***
// Carrier between the readout control and its result bank
`timescale 1ns/1ps
interface result_bank_if;
  logic load;
  logic [143:0] load_data;
  logic [2:0] sel_a;
  logic [2:0] sel_b;
  logic [17:0] res_a;
  logic [17:0] res_b;
  modport ctrl (output load, output load_data, output sel_a, output sel_b, input res_a, input res_b);
  modport bank (input load, input load_data, input sel_a, input sel_b, output res_a, output res_b);
endinterface

// *** design/result_bank.sv ***
// Output data registers holding the last completed sample of all channels
`timescale 1ns/1ps
`include "adc_readout_regs.svh"
module result_bank
  import adc_readout_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  result_bank_if.bank bus
);
  logic [`RESULT_W-1:0] mem_reg [`CHAN_COUNT];

  // Whole bank changes in one edge, so a read never mixes two samples
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < `CHAN_COUNT; i++) begin
        mem_reg[i] <= 18'h00000;
      end
    end else if (bus.load) begin
      for (int i = 0; i < `CHAN_COUNT; i++) begin
        mem_reg[i] <= bus.load_data[i*`RESULT_W +: `RESULT_W];
      end
    end
  end

  assign bus.res_a = mem_reg[bus.sel_a];
  assign bus.res_b = mem_reg[bus.sel_b];
endmodule

// *** testbench/adc_sample_source.sv ***
// Converter model: hands over a fresh set of eight results for every conversion
`timescale 1ns/1ps
module adc_sample_source (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_busy,
  output logic [143:0] o_adc_data
);
  logic [7:0] sample_reg;
  logic busy_reg;
  // New input is taken as the hold starts, so it is steady when results are stored
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sample_reg <= 8'h00;
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= i_busy;
      if (i_busy && !busy_reg) begin
        sample_reg <= sample_reg + 8'h01;
      end
    end
  end
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      o_adc_data[18*n +: 18] = {sample_reg, 10'h000} ^ (18'h0B5A3 + 18'(n) * 18'h005D1);
    end
  end
endmodule

// *** testbench/simul_adc_readout_ctrl_tb.sv ***
// Self-checking bench of the sampling ADC readout control
`timescale 1ns/1ps
`include "adc_readout_regs.svh"
module simul_adc_readout_ctrl_tb;
  import adc_readout_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic trig = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic pd_n = 1'b1;
  logic range = 1'b0;
  logic isel = 1'b0;
  logic sbsel = 1'b0;
  logic high_byte_first_enable = 1'b0;
  logic [143:0] adc_data;
  logic busy, flag, flag_oe_n, fe_on, ref_on;
  logic [15:0] data, oe_n;
  logic [17:0] r;
  logic [17:0] r2;
  int n_mismatch = 0;
  int check_count = 0;
  int cnt;
  int cyc_no = 0;
  int rise_at = 0;

  always #2 clk = ~clk;

  // Edge count, so busy length is measured from its rise however late the wait starts
  always @(posedge clk) cyc_no <= cyc_no + 1;

  adc_sample_source u_adc_sample_source (.i_ref_clk(clk), .i_nrst(nrst), .i_busy(busy), .o_adc_data(adc_data));

  // Common trigger: both group pins driven from one net
  simul_adc_readout_ctrl u_simul_adc_readout_ctrl (
    .i_ref_clk(clk), .i_nrst(nrst), .i_sample_trigger_group1(trig), .i_sample_trigger_group2(trig),
    .i_cs_n(cs_n), .i_rd_n(rd_n), .i_power_down_n(pd_n), .i_range(range), .i_interface_select(isel),
    .i_serial_or_byte_select(sbsel), .i_byte_order_select(high_byte_first_enable), .i_adc_data(adc_data), .o_busy(busy),
    .o_parallel_data_lines(data), .o_parallel_data_oe_n(oe_n), .o_first_channel_flag(flag),
    .o_first_channel_flag_oe_n(flag_oe_n), .o_front_end_power_on(fe_on), .o_reference_power_on(ref_on));

  function automatic logic [17:0] res(input logic [7:0] s, input int n);
    return {s, 10'h000} ^ (18'h0B5A3 + 18'(n) * 18'h005D1);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Release then assert the read strobe; outputs settle three edges after the pin
  task automatic strobe();
    rd_n = 1'b1;
    cyc(3);
    rd_n = 1'b0;
    cyc(4);
  endtask

  task automatic frame_end();
    rd_n = 1'b1;
    cs_n = 1'b1;
    cyc(4);
    chk(oe_n, 16'hFFFF);
    chk(flag_oe_n, 1'b1);
  endtask

  task automatic start_conv();
    trig = 1'b1;
    cnt = 0;
    while (!busy && cnt < 10) begin
      cyc(1);
      cnt++;
    end
    if (!busy) begin
      n_mismatch++;
      end_sim();
    end
    rise_at = cyc_no;
    trig = 1'b0;
  endtask

  task automatic wait_done();
    cnt = 0;
    while (busy && cnt < 600) begin
      cyc(1);
      cnt++;
    end
    if (busy) begin
      n_mismatch++;
      end_sim();
    end
    chk(18'(cyc_no - rise_at), 18'(`CONV_CYCLES));
  endtask

  initial begin
    cyc(20);
    nrst = 1'b1;
    cyc(2);
    chk(busy, 1'b0);
    chk(oe_n, 16'hFFFF);
    chk({fe_on, ref_on}, 2'h3);
    $display("test reset done");
    start_conv();
    cyc(50);
    trig = 1'b1;
    wait_done();
    cyc(10);
    chk(busy, 1'b0);
    trig = 1'b0;
    $display("test conversion done");
    cs_n = 1'b0;
    for (int ch = 0; ch < 8; ch++) begin
      for (int p = 0; p < 2; p++) begin
        strobe();
        r = res(8'h01, ch);
        chk(data, p == 0 ? r[17:2] : {r[1:0], 14'h0000});
        chk(flag, ch == 0);
        chk(oe_n, 16'h0000);
        chk(flag_oe_n, 1'b0);
      end
    end
    frame_end();
    $display("test parallel done");
    isel = 1'b1;
    sbsel = 1'b1;
    for (int hb = 0; hb < 2; hb++) begin
      high_byte_first_enable = hb[0];
      cs_n = 1'b0;
      for (int ch = 0; ch < 8; ch++) begin
        for (int p = 0; p < 3; p++) begin
          strobe();
          r = res(8'h01, ch);
          case (hb == 1 ? p : 2 - p)
            0: chk(data[7:0], r[17:10]);
            1: chk(data[7:0], r[9:2]);
            default: chk(data[7:0], {r[1:0], 6'h00});
          endcase
          chk(oe_n, 16'hFF00);
          chk(flag, ch == 0);
        end
      end
      frame_end();
    end
    $display("test byte done");
    sbsel = 1'b0;
    high_byte_first_enable = 1'b0;
    cs_n = 1'b0;
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 18; k++) begin
        strobe();
        r = res(8'h01, c);
        r2 = res(8'h01, c + 4);
        chk({data[8], data[7]}, {r2[17 - k], r[17 - k]});
        chk(oe_n, 16'hFE7F);
        chk(flag, c == 0);
      end
    end
    frame_end();
    $display("test serial done");
    isel = 1'b0;
    start_conv();
    cs_n = 1'b0;
    strobe();
    chk(data, res(8'h01, 0) >> 2);
    frame_end();
    wait_done();
    cs_n = 1'b0;
    strobe();
    chk(data, res(8'h02, 0) >> 2);
    frame_end();
    $display("test stale read done");
    range = 1'b1;
    pd_n = 1'b0;
    cyc(4);
    chk({fe_on, ref_on}, 2'h1);
    trig = 1'b1;
    cyc(10);
    chk(busy, 1'b0);
    trig = 1'b0;
    pd_n = 1'b1;
    cyc(25000);
    range = 1'b0;
    pd_n = 1'b0;
    cyc(4);
    chk({fe_on, ref_on}, 2'h0);
    pd_n = 1'b1;
    cyc(4);
    nrst = 1'b0;
    cyc(20);
    nrst = 1'b1;
    cyc(2);
    start_conv();
    wait_done();
    $display("test power-down done");
    end_sim();
  end
endmodule
